// ### shared/iwu_pkg.sv
// Package with constants and types of the interrupt and watchdog unit
package iwu_pkg;

	// ==========================================================
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h00;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
	localparam logic [7:0] OFS_POWER_CONTROL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_PRESCALER = 8'h10;
	localparam logic [7:0] OFS_PORT_CONFIG = 8'h14;
	localparam logic [7:0] OFS_CORE_STATE = 8'h18;

	// ==========================================================
	// Field positions
	localparam int FLAG_COUNT = 7;
	localparam int BIT_TIMER0 = 0;
	localparam int BIT_PIN_CHANGE = 1;
	localparam int BIT_EXTERNAL = 2;
	localparam int BIT_TIMER1 = 3;
	localparam int BIT_LOW_VOLTAGE = 4;
	localparam int BIT_NV_WRITE = 5;
	localparam int BIT_WATCHDOG = 6;
	localparam int BIT_WATCHDOG_RUN = 7;
	localparam int BIT_TIMEOUT = 4;
	localparam int BIT_PS_TO_WDT = 3;
	localparam int POS_WAKE_ENABLE = 8;
	localparam int BIT_EXT_SELECT = 16;
	localparam int BIT_EXT_EDGE = 17;
	localparam int PIN_COUNT = 6;

	// ==========================================================
	// Values after reset
	localparam logic [6:0] RST_IRQ_ENABLE = 7'h00;
	localparam logic RST_WATCHDOG_RUN = 1'b1;
	localparam logic RST_TIMEOUT = 1'b1;
	localparam logic [3:0] RST_PRESCALER = 4'h0;
	localparam logic [17:0] RST_PORT_CONFIG = 18'h0003F;
	localparam logic [7:0] RST_SYNC = 8'h40;

	// ==========================================================
	// Watchdog base periods in microseconds, oscillator default
	localparam longint WDT_BASE_US_0 = 3500;
	localparam longint WDT_BASE_US_1 = 15000;
	localparam longint WDT_BASE_US_2 = 60000;
	localparam longint WDT_BASE_US_3 = 250000;
	localparam longint US_PER_S = 1000000;
	localparam int WDT_OSC_HZ_DEFAULT = 32768;
	localparam int WDT_CNT_W = 20;

	// ==========================================================
	// Vectors and bus answers
	localparam logic [10:0] SOFT_VECTOR = 11'h001;
	localparam logic [10:0] HW_VECTOR = 11'h008;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control instructions from the core, one-cycle pulses
	typedef struct packed {
		logic watchdog_clear_instruction;
		logic enable_irq_instruction;
		logic disable_irq_instruction;
		logic return_from_irq_instruction;
		logic soft_irq_instruction;
	} iwu_instr_t;

	// Configuration words, static while running
	typedef struct packed {
		logic wdt_present;
		logic wdt_irq_mode;
		logic [1:0] wdt_period_sel;
	} iwu_config_t;

	// Peripheral event sources
	typedef struct packed {
		logic [7:0] timer0_value;
		logic [9:0] timer1_value;
		logic nv_write_done;
	} iwu_events_t;

endpackage : iwu_pkg

// ### hdl/iwu_top.sv
// Interrupt controller and watchdog timer with AXI4-Lite registers
`timescale 1ns/10ps
// ==========================================================
module iwu_top #(
	parameter int WDT_OSC_HZ = iwu_pkg::WDT_OSC_HZ_DEFAULT,
	parameter int WDT_TICKS_0 = int'(iwu_pkg::WDT_BASE_US_0
		* WDT_OSC_HZ / iwu_pkg::US_PER_S),
	parameter int WDT_TICKS_1 = int'(iwu_pkg::WDT_BASE_US_1
		* WDT_OSC_HZ / iwu_pkg::US_PER_S),
	parameter int WDT_TICKS_2 = int'(iwu_pkg::WDT_BASE_US_2
		* WDT_OSC_HZ / iwu_pkg::US_PER_S),
	parameter int WDT_TICKS_3 = int'(iwu_pkg::WDT_BASE_US_3
		* WDT_OSC_HZ / iwu_pkg::US_PER_S)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire iwu_pkg::iwu_instr_t core_instr,
	input wire iwu_pkg::iwu_config_t config_word,
	input wire iwu_pkg::iwu_events_t periph_events,
	input wire logic [5:0] port_pin,
	input wire logic low_voltage_out,
	input wire logic wdt_osc,
	output logic redirect_valid,
	output logic [10:0] redirect_addr,
	output logic wdt_reset_req,
	output logic global_irq_enable
);

	// ==========================================================
	// Register state
	logic [6:0] irq_flag_reg;
	logic [6:0] irq_flag_next;
	logic [6:0] irq_enable_reg;
	logic watchdog_run_bit_reg;
	logic timeout_status_flag_reg;
	logic [3:0] prescaler_reg;
	logic [17:0] port_config_reg;
	logic global_irq_enable_reg;
	logic redirect_valid_reg;
	logic [10:0] redirect_addr_reg;
	logic wdt_reset_req_reg;

	// ==========================================================
	// Synchronisers: {osc, low voltage, pins}
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic [7:0] sync_prev_reg;
	logic [7:0] tmr0_prev_reg;
	logic [9:0] tmr1_prev_reg;

	// Pins and oscillator arrive unsynchronised; two flops first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= iwu_pkg::RST_SYNC;
			sync2_reg <= iwu_pkg::RST_SYNC;
			sync_prev_reg <= iwu_pkg::RST_SYNC;
		end else begin
			sync1_reg <= {wdt_osc, low_voltage_out, port_pin};
			sync2_reg <= sync1_reg;
			sync_prev_reg <= sync2_reg;
		end
	end

	// Previous timer values for wrap detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tmr0_prev_reg <= 8'h00;
			tmr1_prev_reg <= 10'h000;
		end else begin
			tmr0_prev_reg <= periph_events.timer0_value;
			tmr1_prev_reg <= periph_events.timer1_value;
		end
	end

	// ==========================================================
	// Event detection
	wire [5:0] pins_now = sync2_reg[5:0];
	wire [5:0] pins_old = sync_prev_reg[5:0];
	wire [5:0] pin_dir_in = port_config_reg[5:0];
	wire [5:0] pin_wake_enable = port_config_reg[13:8];
	wire external_irq_select = port_config_reg[iwu_pkg::BIT_EXT_SELECT];
	wire external_edge_select = port_config_reg[iwu_pkg::BIT_EXT_EDGE];
	wire [5:0] pin_watch = pin_dir_in & pin_wake_enable
		& {5'h1F, ~external_irq_select};
	wire pin_change_evt = |((pins_now ^ pins_old) & pin_watch);
	wire pin0_rise = pins_now[0] & ~pins_old[0];
	wire pin0_fall = ~pins_now[0] & pins_old[0];
	wire ext_evt = external_irq_select
		& (external_edge_select ? pin0_rise : pin0_fall);
	wire lvd_evt = sync_prev_reg[6] & ~sync2_reg[6];
	wire osc_tick = sync2_reg[7] & ~sync_prev_reg[7];
	wire timer0_evt = (tmr0_prev_reg == 8'h00)
		& (periph_events.timer0_value == 8'hFF);
	wire timer1_evt = (tmr1_prev_reg == 10'h3FF)
		& (periph_events.timer1_value == 10'h000);
	wire nv_evt = periph_events.nv_write_done;

	// ==========================================================
	// Watchdog and shared prescaler
	logic [7:0] ps_cnt_reg;
	logic [iwu_pkg::WDT_CNT_W-1:0] wdt_cnt_reg;
	logic [iwu_pkg::WDT_CNT_W-1:0] wdt_last;
	wire [2:0] prescaler_ratio_select = prescaler_reg[2:0];
	wire prescaler_to_watchdog_bit =
		prescaler_reg[iwu_pkg::BIT_PS_TO_WDT];
	wire wdt_active = config_word.wdt_present & watchdog_run_bit_reg;
	wire clear_cmd = core_instr.watchdog_clear_instruction;
	// Interrupt mode divides one step further than reset mode
	wire [8:0] ps_div = config_word.wdt_irq_mode
		? (9'h002 << prescaler_ratio_select)
		: (9'h001 << prescaler_ratio_select);
	wire ps_hit = ({1'b0, ps_cnt_reg} == ps_div - 9'h001);
	wire wdt_step = wdt_active & osc_tick
		& (~prescaler_to_watchdog_bit | ps_hit);
	wire wdt_expire = wdt_step & ~clear_cmd
		& (wdt_cnt_reg == wdt_last);
	wire wdt_irq_evt = wdt_expire & config_word.wdt_irq_mode;

	// Base period chosen by configuration bits
	always_comb begin
		case (config_word.wdt_period_sel)
		2'h0: wdt_last = iwu_pkg::WDT_CNT_W'(WDT_TICKS_0 - 1);
		2'h1: wdt_last = iwu_pkg::WDT_CNT_W'(WDT_TICKS_1 - 1);
		2'h2: wdt_last = iwu_pkg::WDT_CNT_W'(WDT_TICKS_2 - 1);
		default: wdt_last = iwu_pkg::WDT_CNT_W'(WDT_TICKS_3 - 1);
		endcase
	end

	// Prescaler held at zero unless lent to the running watchdog
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ps_cnt_reg <= 8'h00;
		end else if (!wdt_active || !prescaler_to_watchdog_bit
			|| clear_cmd) begin
			ps_cnt_reg <= 8'h00;
		end else if (osc_tick) begin
			ps_cnt_reg <= ps_hit ? 8'h00 : ps_cnt_reg + 8'h01;
		end
	end

	// Watchdog counter; clear instruction restarts it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_cnt_reg <= '0;
		end else if (clear_cmd || !wdt_active || wdt_expire) begin
			wdt_cnt_reg <= '0;
		end else if (wdt_step) begin
			wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
		end
	end

	// Timeout flag and chip reset request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_status_flag_reg <= iwu_pkg::RST_TIMEOUT;
			wdt_reset_req_reg <= 1'b0;
		end else begin
			wdt_reset_req_reg <= wdt_expire
				& ~config_word.wdt_irq_mode;
			if (clear_cmd && prescaler_to_watchdog_bit) begin
				timeout_status_flag_reg <= 1'b1;
			end else if (wdt_expire) begin
				timeout_status_flag_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite write path; address and data taken in any order
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
		{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	wire wr_flag = do_write & (waddr_reg == iwu_pkg::OFS_IRQ_FLAG);
	wire wr_enable = do_write & (waddr_reg == iwu_pkg::OFS_IRQ_ENABLE);
	wire wr_power = do_write
		& (waddr_reg == iwu_pkg::OFS_POWER_CONTROL);
	wire wr_presc = do_write & (waddr_reg == iwu_pkg::OFS_PRESCALER);
	wire wr_port = do_write & (waddr_reg == iwu_pkg::OFS_PORT_CONFIG);
	wire wr_known = wr_flag | wr_enable | wr_power | wr_presc | wr_port
		| (waddr_reg == iwu_pkg::OFS_STATUS)
		| (waddr_reg == iwu_pkg::OFS_CORE_STATE);
	wire [31:0] port_merged = ({14'h0000, port_config_reg} & ~wmask)
		| (wdata_reg & wmask);

	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;

	// Capture address and data, answer once both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= iwu_pkg::RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_hold_reg <= 1'b1;
				waddr_reg <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (w_fire) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_known ? iwu_pkg::RESP_OKAY
					: iwu_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Software-written control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_enable_reg <= iwu_pkg::RST_IRQ_ENABLE;
			watchdog_run_bit_reg <= iwu_pkg::RST_WATCHDOG_RUN;
			prescaler_reg <= iwu_pkg::RST_PRESCALER;
			port_config_reg <= iwu_pkg::RST_PORT_CONFIG;
		end else begin
			if (wr_enable && wstrb_reg[0]) begin
				irq_enable_reg <= wdata_reg[6:0];
			end
			if (wr_power && wstrb_reg[0]) begin
				watchdog_run_bit_reg <=
					wdata_reg[iwu_pkg::BIT_WATCHDOG_RUN];
			end
			if (wr_presc && wstrb_reg[0]) begin
				prescaler_reg <= wdata_reg[3:0];
			end
			if (wr_port) begin
				port_config_reg <= port_merged[17:0];
			end
		end
	end

	// ==========================================================
	// Interrupt flags, one per source
	wire [6:0] hw_event = {wdt_irq_evt, nv_evt, lvd_evt, timer1_evt,
		ext_evt, pin_change_evt, timer0_evt};

	genvar gi;
	generate
		for (gi = 0; gi < iwu_pkg::FLAG_COUNT; gi++) begin : g_flag
			// Writing 0 clears; an event in the same cycle wins
			assign irq_flag_next[gi] = hw_event[gi]
				| (irq_flag_reg[gi] & ~(wr_flag & wstrb_reg[0]
				& ~wdata_reg[gi]));
		end
	endgenerate

	// Flags cleared only by reset or through the flag register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_flag_reg <= 7'h00;
		end else begin
			irq_flag_reg <= irq_flag_next;
		end
	end

	// ==========================================================
	// Global enable and vector redirection
	wire [6:0] irq_visible = irq_flag_reg & irq_enable_reg;
	wire irq_pending = |irq_visible;
	wire soft_take = core_instr.soft_irq_instruction;
	wire hw_take = global_irq_enable_reg & irq_pending
		& ~soft_take;

	// Software interrupt ignores the enable; taking any clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_irq_enable_reg <= 1'b0;
			redirect_valid_reg <= 1'b0;
			redirect_addr_reg <= 11'h000;
		end else begin
			redirect_valid_reg <= soft_take | hw_take;
			if (soft_take) begin
				redirect_addr_reg <= iwu_pkg::SOFT_VECTOR;
			end else if (hw_take) begin
				redirect_addr_reg <= iwu_pkg::HW_VECTOR;
			end
			if (soft_take || hw_take) begin
				global_irq_enable_reg <= 1'b0;
			end else if (core_instr.return_from_irq_instruction) begin
				global_irq_enable_reg <= 1'b1;
			end else if (core_instr.enable_irq_instruction) begin
				global_irq_enable_reg <= 1'b1;
			end else if (core_instr.disable_irq_instruction) begin
				global_irq_enable_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// AXI4-Lite read path; one read in flight
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rd_mux;
	logic rd_known;
	wire [7:0] raddr = {s_axi_araddr[7:2], 2'h0};
	wire ar_fire = s_axi_arvalid & s_axi_arready;

	assign s_axi_arready = ~rvalid_reg;

	// Read selection; reserved bits read as zero
	always_comb begin
		rd_known = 1'b1;
		case (raddr)
		iwu_pkg::OFS_IRQ_FLAG: rd_mux = {25'h0, irq_visible};
		iwu_pkg::OFS_IRQ_ENABLE: rd_mux = {25'h0, irq_enable_reg};
		iwu_pkg::OFS_POWER_CONTROL:
			rd_mux = {24'h0, watchdog_run_bit_reg, 7'h00};
		iwu_pkg::OFS_STATUS:
			rd_mux = {27'h0, timeout_status_flag_reg, 4'h0};
		iwu_pkg::OFS_PRESCALER: rd_mux = {28'h0, prescaler_reg};
		iwu_pkg::OFS_PORT_CONFIG: rd_mux = {14'h0, port_config_reg};
		iwu_pkg::OFS_CORE_STATE:
			rd_mux = {30'h0, irq_pending, global_irq_enable_reg};
		default: begin
			rd_mux = 32'h00000000;
			rd_known = 1'b0;
		end
		endcase
	end

	// Read data held until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= iwu_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_known ? iwu_pkg::RESP_OKAY
				: iwu_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign redirect_valid = redirect_valid_reg;
	assign redirect_addr = redirect_addr_reg;
	assign wdt_reset_req = wdt_reset_req_reg;
	assign global_irq_enable = global_irq_enable_reg;

endmodule : iwu_top

// ### test/iwu_top_properties.sv
// Port checker of the interrupt and watchdog unit
`timescale 1ns/10ps
// ==========================================================
// Checker module
module iwu_top_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire iwu_pkg::iwu_instr_t core_instr,
	input wire iwu_pkg::iwu_config_t config_word,
	input wire logic redirect_valid,
	input wire logic [10:0] redirect_addr,
	input wire logic wdt_reset_req,
	input wire logic global_irq_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic armed;
	// Hides the reset edge from the change check
	always_ff @(posedge aclk) begin
		armed <= aresetn;
	end
	// Vector, enable, instruction and watchdog request relations
	AST_SOFT_JUMP: assert property (
		core_instr.soft_irq_instruction |=> redirect_valid
		&& redirect_addr == iwu_pkg::SOFT_VECTOR && !global_irq_enable)
		else $error("soft jump wrong");
	AST_HW_JUMP: assert property (
		(!core_instr.soft_irq_instruction ##1 redirect_valid)
		|-> redirect_addr == iwu_pkg::HW_VECTOR)
		else $error("hardware vector wrong");
	AST_TAKE_CLEARS: assert property (
		redirect_valid |-> !global_irq_enable)
		else $error("enable left set on take");
	AST_NO_TAKE: assert property (
		!global_irq_enable && !core_instr.soft_irq_instruction
		|=> !redirect_valid)
		else $error("take with enable low");
	AST_ENABLE_SETS: assert property (
		core_instr.enable_irq_instruction && !global_irq_enable
		|=> global_irq_enable)
		else $error("enable instruction ignored");
	AST_DISABLE_CLEARS: assert property (
		core_instr.disable_irq_instruction |=> !global_irq_enable)
		else $error("disable instruction ignored");
	AST_RETURN_SETS: assert property (
		core_instr.return_from_irq_instruction && !global_irq_enable
		|=> global_irq_enable)
		else $error("return left enable low");
	AST_GIE_CAUSE: assert property (
		armed && $changed(global_irq_enable)
		|-> $past(|core_instr) || redirect_valid)
		else $error("enable moved without cause");
	AST_WDT_PULSE: assert property (
		wdt_reset_req |=> !wdt_reset_req)
		else $error("reset request too long");
	AST_WDT_MODE: assert property (
		config_word.wdt_irq_mode || !config_word.wdt_present
		|-> !wdt_reset_req)
		else $error("reset request in wrong mode");
	COV_SOFT: cover property (core_instr.soft_irq_instruction);
	COV_HW: cover property (redirect_valid && global_irq_enable == 1'h0);
	COV_WDT: cover property (wdt_reset_req);
endmodule : iwu_top_checker

bind iwu_top iwu_top_checker chk_u (.*);

// ### test/iwu_core_model.sv
// Behavioural core issuing control instructions
`timescale 1ns/10ps
// ==========================================================
// Core model
module iwu_core_model (
	input wire logic aclk,
	output iwu_pkg::iwu_instr_t core_instr
);
	logic last_enable = 1'h0;
	initial core_instr = '0;
	// One-cycle pulse; always an idle cycle between two
	task automatic issue(input logic [4:0] ins);
		@(posedge aclk);
		// Keeps enable away from a following return
		if (ins[1] && last_enable) begin
			@(posedge aclk);
		end
		core_instr <= iwu_pkg::iwu_instr_t'(ins);
		last_enable = ins[3];
		@(posedge aclk);
		core_instr <= '0;
	endtask : issue
endmodule : iwu_core_model

// ### test/interrupt_and_watchdog_unit_bench.sv
// Self-checking bench of the interrupt and watchdog unit
`timescale 1ns/10ps
// ==========================================================
// Bench top
module interrupt_and_watchdog_unit_bench;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	iwu_pkg::iwu_instr_t core_instr;
	iwu_pkg::iwu_config_t config_word = 4'h8;
	iwu_pkg::iwu_events_t periph_events = {8'h10, 10'h100, 1'h0};
	logic [5:0] port_pin = 6'h00;
	logic low_voltage_out = 1'h1;
	logic wdt_osc = 1'h0;
	logic osc_run = 1'h0;
	logic [1:0] osc_div = 2'h0;
	logic redirect_valid, wdt_reset_req, global_irq_enable;
	logic [10:0] redirect_addr;
	int fails = 0;
	int checks_done = 0;
	localparam logic [1:0] OK = iwu_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = iwu_pkg::RESP_SLVERR;

	// Small tick counts keep the watchdog runs short
	iwu_top #(.WDT_TICKS_0(4), .WDT_TICKS_1(6), .WDT_TICKS_2(8),
		.WDT_TICKS_3(10)) dut_u (.*);
	iwu_core_model core_u (.aclk(aclk), .core_instr(core_instr));

	// ==========================================================
	// Clocks
	always #12.5 aclk = ~aclk;
	// Slow oscillator, one edge every four cycles
	always @(posedge aclk) begin
		osc_div <= osc_div + 2'h1;
		if (osc_run && osc_div == 2'h3) wdt_osc <= ~wdt_osc;
	end

	// ==========================================================
	// Tasks
	task automatic close_out();
		$display("Counts: fails=%0d checks=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Config changes only while reset is held
	task automatic do_reset(input logic [3:0] cfg);
		@(posedge aclk);
		aresetn <= 1'h0;
		config_word <= iwu_pkg::iwu_config_t'(cfg);
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
	endtask : do_reset

	// Handshakes sampled 1 ns after an edge, valid for the next edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		logic [1:0] resp;
		n = 0;
		b_ok = 1'h0;
		resp = 2'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			#1;
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok = s_axi_wvalid && s_axi_wready;
			b_ok = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			n++;
			if (aw_ok) s_axi_awvalid <= 1'h0;
			if (w_ok) s_axi_wvalid <= 1'h0;
		end while (!b_ok && n < 40);
		s_axi_bready <= 1'h0;
		chk(32'({b_ok, resp}), 32'({1'h1, er}));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		int n;
		logic ar_ok;
		logic r_ok;
		logic [1:0] resp;
		logic [31:0] data;
		n = 0;
		r_ok = 1'h0;
		resp = 2'h0;
		data = 32'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			#1;
			ar_ok = s_axi_arvalid && s_axi_arready;
			r_ok = s_axi_rvalid;
			resp = s_axi_rresp;
			data = s_axi_rdata;
			@(posedge aclk);
			n++;
			if (ar_ok) s_axi_arvalid <= 1'h0;
		end while (!r_ok && n < 40);
		s_axi_rready <= 1'h0;
		chk(32'({r_ok, resp}), 32'({1'h1, er}));
		chk(data, exp);
	endtask : rd

	task automatic jump(input logic [10:0] va);
		int n;
		n = 0;
		// One-cycle pulse may already stand when called
		#1;
		while (!redirect_valid && n < 10) begin
			@(posedge aclk);
			#1;
			n++;
		end
		chk(32'({redirect_valid, redirect_addr, global_irq_enable}),
			32'({1'h1, va, 1'h0}));
	endtask : jump

	task automatic wdt_wait(input logic exp);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			#1;
			n++;
		end while (!wdt_reset_req && n < 400);
		chk(32'(wdt_reset_req), 32'(exp));
	endtask : wdt_wait

	task automatic t0_wrap();
		@(posedge aclk);
		periph_events.timer0_value <= 8'h00;
		@(posedge aclk);
		periph_events.timer0_value <= 8'hFF;
		repeat (4) @(posedge aclk);
	endtask : t0_wrap

	// Every event source but the external pin and the watchdog, then timer0
	task automatic fire_all();
		@(posedge aclk);
		periph_events.timer1_value <= 10'h3FF;
		periph_events.nv_write_done <= 1'h1;
		low_voltage_out <= 1'h0;
		port_pin[1] <= 1'h1;
		@(posedge aclk);
		periph_events.timer1_value <= 10'h000;
		periph_events.nv_write_done <= 1'h0;
		repeat (2) @(posedge aclk);
		low_voltage_out <= 1'h1;
		t0_wrap();
	endtask : fire_all

	// ==========================================================
	// Hang guard
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		close_out();
	end

	// ==========================================================
	// Main sequence
	initial begin
		do_reset(4'h8);
		rd(iwu_pkg::OFS_IRQ_FLAG, 32'h0, OK);
		rd(iwu_pkg::OFS_IRQ_ENABLE, 32'h0, OK);
		rd(iwu_pkg::OFS_POWER_CONTROL, 32'h80, OK);
		wr(iwu_pkg::OFS_STATUS, 32'h0, OK);
		rd(iwu_pkg::OFS_STATUS, 32'h10, OK);
		rd(iwu_pkg::OFS_PRESCALER, 32'h0, OK);
		rd(iwu_pkg::OFS_PORT_CONFIG, 32'h3F, OK);
		rd(8'h1C, 32'h0, ERR);
		wr(8'h1C, 32'hFF, ERR);
		// Flags hidden while enables are low
		wr(iwu_pkg::OFS_PORT_CONFIG, 32'h0000023F, OK);
		fire_all();
		rd(iwu_pkg::OFS_IRQ_FLAG, 32'h0, OK);
		wr(iwu_pkg::OFS_IRQ_ENABLE, 32'h7F, OK);
		// No byte lane strobed: enables must stay as written
		s_axi_wstrb <= 4'h0;
		wr(iwu_pkg::OFS_IRQ_ENABLE, 32'h0, OK);
		s_axi_wstrb <= 4'hF;
		rd(iwu_pkg::OFS_IRQ_FLAG, 32'h3B, OK);
		wr(iwu_pkg::OFS_IRQ_FLAG, 32'h7E, OK);
		rd(iwu_pkg::OFS_IRQ_FLAG, 32'h3A, OK);
		wr(iwu_pkg::OFS_IRQ_FLAG, 32'h0, OK);
		// Pin zero as external input, rising edge
		wr(iwu_pkg::OFS_PORT_CONFIG, 32'h0003013F, OK);
		port_pin[0] <= 1'h1;
		repeat (6) @(posedge aclk);
		rd(iwu_pkg::OFS_IRQ_FLAG, 32'h04, OK);
		wr(iwu_pkg::OFS_IRQ_FLAG, 32'h0, OK);
		port_pin[0] <= 1'h0;
		repeat (6) @(posedge aclk);
		rd(iwu_pkg::OFS_IRQ_FLAG, 32'h0, OK);
		// Hardware take, then software jump with enable low
		wr(iwu_pkg::OFS_IRQ_ENABLE, 32'h01, OK);
		t0_wrap();
		core_u.issue(5'h08);
		jump(iwu_pkg::HW_VECTOR);
		rd(iwu_pkg::OFS_CORE_STATE, 32'h2, OK);
		wr(iwu_pkg::OFS_IRQ_FLAG, 32'h0, OK);
		core_u.issue(5'h01);
		jump(iwu_pkg::SOFT_VECTOR);
		core_u.issue(5'h02);
		rd(iwu_pkg::OFS_CORE_STATE, 32'h1, OK);
		core_u.issue(5'h04);
		rd(iwu_pkg::OFS_CORE_STATE, 32'h0, OK);
		// Watchdog in reset mode with the prescaler borrowed
		wr(iwu_pkg::OFS_PRESCALER, 32'h08, OK);
		osc_run <= 1'h1;
		wdt_wait(1'h1);
		rd(iwu_pkg::OFS_STATUS, 32'h0, OK);
		core_u.issue(5'h10);
		rd(iwu_pkg::OFS_STATUS, 32'h10, OK);
		wr(iwu_pkg::OFS_POWER_CONTROL, 32'h0, OK);
		wdt_wait(1'h0);
		// Watchdog in interrupt mode
		do_reset(4'hC);
		wr(iwu_pkg::OFS_IRQ_ENABLE, 32'h40, OK);
		repeat (300) @(posedge aclk);
		rd(iwu_pkg::OFS_IRQ_FLAG, 32'h40, OK);
		close_out();
	end
endmodule : interrupt_and_watchdog_unit_bench
